// [sfb_dev.sv]
// Bridge end of the parallel FIFO bus, with its two data FIFOs.
// Assumes the master end samples on the same clk edge as this end.
`timescale 1ns/10ps

// ------------------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------------------
module sfb_fifo #(
  parameter int W     = sfb_pkg::DATA_W,
  parameter int DEPTH = sfb_pkg::FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("Depth must be a power of two of at least 2.");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  wire          push;
  wire          pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + (AW + 1)'(push);
      rd_ptr <= rd_ptr + (AW + 1)'(pop);
    end
  end
endmodule

// ------------------------------------------------------------------------
// Bridge end
// ------------------------------------------------------------------------
module sfb_dev #(
  parameter int W       = sfb_pkg::DATA_W,
  parameter int DEPTH   = sfb_pkg::FIFO_DEPTH,
  parameter int BUS_KHZ = sfb_pkg::BUS_KHZ_FAST,
  parameter int IO_MV   = 3300
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire sfb_pkg::sfb_mode_t mode,
  input  wire logic              usb_suspend,
  output logic                   remote_wakeup,
  output logic                   core_reset,
  input  wire logic [W-1:0]      usb_rx_data,
  input  wire logic              usb_rx_valid,
  output logic                   usb_rx_ready,
  output logic [W-1:0]           usb_tx_data,
  output logic                   usb_tx_valid,
  input  wire logic              usb_tx_ready,
  sfb_if.device                  bus
);
  typedef enum logic {SFB_IDLE, SFB_DATA} sfb_phase_t;

  // The fast rate is refused on a 1.8V supply.
  if (!(BUS_KHZ == sfb_pkg::BUS_KHZ_SLOW
      || (BUS_KHZ == sfb_pkg::BUS_KHZ_FAST && IO_MV >= sfb_pkg::IO_MV_FAST))
      || IO_MV < sfb_pkg::IO_MV_LOW || W < 16)
  begin : g_bad_cfg
    $error("Unsupported bus rate, supply or data width.");
  end

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  sfb_phase_t   phase;
  sfb_phase_t   next_phase;
  logic         cmd_write;
  logic         out_valid;
  logic [W-1:0] out_data;
  logic         wake_prev;
  logic         bus_clk_q;
  logic [W-1:0] rx_head;
  logic         rx_head_valid;
  logic         tx_in_ready;
  wire          single;
  wire          in_data_phase;
  wire          wr_req;
  wire          rd_take;
  wire          stage_load;
  wire  [7:0]   status;
  wire  [W-1:0] status_word;
  wire  [W-1:0] status_mask;

  // Chip reset pin and local reset both clear everything.
  assign core_reset    = rst | ~bus.reset_n;
  assign single        = mode == sfb_pkg::SFB_MODE_SINGLE;
  assign in_data_phase = ~single & (phase == SFB_DATA);

  // Strobe-low write in single mode, data phase write in multi.
  assign wr_req  = single ? ~bus.wr_n
                          : in_data_phase & cmd_write & ~bus.wr_n;
  // A single read needs rd_n and oe_n low, a multi read wr_n low in its data phase.
  assign rd_take = out_valid & (single ? ~bus.rd_n & ~bus.oe_n
                  : in_data_phase & ~cmd_write & ~bus.wr_n);
  assign stage_load = ~out_valid | rd_take;

  // Status nibbles are active low: OUT data waiting, IN space free.
  assign status      = {3'h7, ~out_valid, 3'h7, ~tx_in_ready};
  assign status_word = W'(status) << sfb_pkg::STAT_LO;
  assign status_mask = W'(sfb_pkg::STAT_FIELD) << sfb_pkg::STAT_LO;

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  assign bus.rx_avail_flag_n = single ? ~out_valid
    : ~(in_data_phase & (cmd_write ? tx_in_ready : out_valid));
  assign bus.tx_space_flag_n = single ? ~tx_in_ready
    : ~(phase == SFB_IDLE);
  assign bus.dev_data_o  = (~single & phase == SFB_IDLE) ? status_word
                                                          : out_data;
  // Data is released once the strobe rises, so the master never fights us.
  assign bus.dev_data_oe = single ? {W{~bus.oe_n}}
    : (phase == SFB_IDLE) ? status_mask
    : {W{~cmd_write & ~bus.wr_n}};
  assign bus.bus_clk     = bus_clk_q;
  // Released in suspend so the pull-up shows high.
  assign bus.dev_wake_o  = 1'b0;
  assign bus.dev_wake_oe = ~usb_suspend;

  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      SFB_IDLE:
        if (~single & ~bus.wr_n)
          next_phase = SFB_DATA;
      SFB_DATA:
        if (single | bus.wr_n)
          next_phase = SFB_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Everything below samples on the rising edge.
  always_ff @(posedge clk)
  begin
    if (core_reset)
    begin
      phase     <= SFB_IDLE;
      cmd_write <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
      bus_clk_q <= 1'b0;
    end
    else
    begin
      phase     <= next_phase;
      bus_clk_q <= ~bus_clk_q;
      if (phase == SFB_IDLE && next_phase == SFB_DATA)
        cmd_write <= bus.be == sfb_pkg::BE_CMD_WRITE;
      // Output stage keeps bus data in a flop ahead of the FIFO.
      if (stage_load)
      begin
        out_valid <= rx_head_valid;
        out_data  <= rx_head;
      end
    end
  end

  // A falling wake pin while suspended asks the host to resume.
  always_ff @(posedge clk)
  begin
    if (core_reset)
    begin
      wake_prev     <= 1'b1;
      remote_wakeup <= 1'b0;
    end
    else
    begin
      wake_prev     <= bus.wake;
      remote_wakeup <= usb_suspend & wake_prev & ~bus.wake;
    end
  end

  // ----------------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------------
  sfb_fifo #(.W(W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rst       (core_reset),
    .in_data   (usb_rx_data),
    .in_valid  (usb_rx_valid),
    .in_ready  (usb_rx_ready),
    .out_data  (rx_head),
    .out_valid (rx_head_valid),
    .out_ready (stage_load)
  );

  // A full buffer raises the transmit flag in single mode, the IN status bit in multi, and stalls the master.
  sfb_fifo #(.W(W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk       (clk),
    .rst       (core_reset),
    .in_data   (bus.data),
    .in_valid  (wr_req),
    .in_ready  (tx_in_ready),
    .out_data  (usb_tx_data),
    .out_valid (usb_tx_valid),
    .out_ready (usb_tx_ready)
  );
endmodule

// [sfb_host.sv]
// Bus master end of the parallel FIFO bus, one word per request.
// Assumes it shares clk with the bridge end and samples on rising edges.
`timescale 1ns/10ps
module sfb_host #(
  parameter int W = sfb_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire sfb_pkg::sfb_mode_t mode,
  input  wire logic              chip_reset,
  input  wire logic              wake_req,
  output logic                   suspended,
  input  wire logic [W-1:0]      send_data,
  input  wire logic              send_valid,
  output logic                   send_ready,
  output logic [W-1:0]           recv_data,
  output logic                   recv_valid,
  input  wire logic              recv_ready,
  sfb_if.host                    bus
);
  typedef enum logic [1:0] {SFB_H_IDLE, SFB_H_CMD, SFB_H_XFER} sfb_hst_t;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  sfb_hst_t     st;
  sfb_hst_t     next_st;
  logic         buf_full;
  logic [W-1:0] buf_data;
  logic         xfer_write;
  logic         reset_q;
  wire          single;
  wire          s_wr;
  wire          s_rd;
  wire          m_done;
  wire          m_start_wr;
  wire          m_start_rd;
  wire  [W-1:0] stat_mask;

  assign single     = mode == sfb_pkg::SFB_MODE_SINGLE;
  // Writes only while space is flagged, reads only while data is.
  assign s_wr       = single & buf_full & ~bus.tx_space_flag_n;
  assign s_rd       = single & ~s_wr & recv_ready
                    & ~bus.rx_avail_flag_n;
  assign m_done     = (st == SFB_H_XFER) & ~bus.rx_avail_flag_n;
  assign m_start_wr = buf_full & ~bus.data[sfb_pkg::STAT_IN_BIT];
  assign m_start_rd = recv_ready & ~bus.data[sfb_pkg::STAT_OUT_BIT];
  assign stat_mask  = W'(sfb_pkg::STAT_FIELD) << sfb_pkg::STAT_LO;
  assign send_ready = ~buf_full;

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  assign bus.wr_n = single ? ~s_wr
                           : ~(st == SFB_H_CMD || st == SFB_H_XFER);
  assign bus.rd_n = ~s_rd;
  assign bus.oe_n = ~s_rd;
  assign bus.be   = (st == SFB_H_CMD) ? (xfer_write ? sfb_pkg::BE_CMD_WRITE
                                                    : sfb_pkg::BE_CMD_READ)
                                      : sfb_pkg::BE_IDLE;
  assign bus.host_data_o  = (st == SFB_H_CMD)
                          ? (~stat_mask & ~W'(8'hff)) | W'(sfb_pkg::CHAN_ONE)
                          : (st == SFB_H_XFER || single) ? buf_data
                          : ~stat_mask;
  // Status byte lanes are left to the bridge outside the data phase.
  assign bus.host_data_oe = single ? {W{s_wr}}
    : (st == SFB_H_XFER) ? {W{xfer_write}}
    : ~stat_mask;
  assign bus.reset_n      = reset_q;
  assign bus.host_wake_o  = 1'b0;
  assign bus.host_wake_oe = wake_req;

  always_comb
  begin
    next_st = st;
    unique case (st)
      SFB_H_IDLE:
        if (~single & (m_start_wr | m_start_rd))
          next_st = SFB_H_CMD;
      SFB_H_CMD:
        next_st = SFB_H_XFER;
      SFB_H_XFER:
        if (m_done)
          next_st = SFB_H_IDLE;
      default:
        next_st = SFB_H_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st         <= SFB_H_IDLE;
      buf_full   <= 1'b0;
      buf_data   <= '0;
      xfer_write <= 1'b0;
      recv_valid <= 1'b0;
      recv_data  <= '0;
      reset_q    <= 1'b0;
      suspended  <= 1'b0;
    end
    else
    begin
      st         <= next_st;
      reset_q    <= ~chip_reset;
      suspended  <= bus.wake;
      recv_valid <= s_rd | (m_done & ~xfer_write);
      if (s_rd | (m_done & ~xfer_write))
        recv_data <= bus.data;
      if (st == SFB_H_IDLE)
        xfer_write <= m_start_wr;
      if (send_valid & ~buf_full)
      begin
        buf_full <= 1'b1;
        buf_data <= send_data;
      end
      else if (s_wr | (m_done & xfer_write))
        buf_full <= 1'b0;
    end
  end
endmodule

// [sfb_if.sv]
// Pin-level carrier between the bridge end and the bus master end.
// Assumes one end binds each modport; pull-ups are modelled here.
`timescale 1ns/10ps
interface sfb_if #(
  parameter int W = sfb_pkg::DATA_W
);
  logic                     bus_clk;
  logic [W-1:0]             dev_data_o;
  logic [W-1:0]             dev_data_oe;
  logic [W-1:0]             host_data_o;
  logic [W-1:0]             host_data_oe;
  wire  [W-1:0]             data;
  logic [sfb_pkg::BE_W-1:0] be;
  logic                     tx_space_flag_n;
  logic                     rx_avail_flag_n;
  logic                     wr_n;
  logic                     rd_n;
  logic                     oe_n;
  logic                     reset_n;
  logic                     dev_wake_o;
  logic                     dev_wake_oe;
  logic                     host_wake_o;
  logic                     host_wake_oe;
  wire                      wake;

  // Undriven lines float high through pull-ups.
  assign data = (dev_data_o & dev_data_oe) | (host_data_o & host_data_oe)
              | ~(dev_data_oe | host_data_oe);
  assign wake = (~dev_wake_oe | dev_wake_o) & (~host_wake_oe | host_wake_o);

  modport device (
    output bus_clk, dev_data_o, dev_data_oe, tx_space_flag_n,
           rx_avail_flag_n, dev_wake_o, dev_wake_oe,
    input  data, be, wr_n, rd_n, oe_n, reset_n, wake
  );

  modport host (
    output host_data_o, host_data_oe, be, wr_n, rd_n, oe_n, reset_n,
           host_wake_o, host_wake_oe,
    input  bus_clk, data, tx_space_flag_n, rx_avail_flag_n, wake
  );
endinterface

// [sfb_monitor.sv]
// Concurrent checks on the bus signals between the two ends.
// Assumes one clock, clk, with synchronous active-high rst.
`timescale 1ns/10ps
module sfb_monitor #(
  parameter int W = sfb_pkg::DATA_W
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire sfb_pkg::sfb_mode_t       mode,
  input wire logic                     bus_clk,
  input wire logic [W-1:0]             data,
  input wire logic [W-1:0]             dev_data_oe,
  input wire logic [sfb_pkg::BE_W-1:0] be,
  input wire logic                     tx_space_flag_n,
  input wire logic                     rx_avail_flag_n,
  input wire logic                     wr_n,
  input wire logic                     rd_n,
  input wire logic                     oe_n,
  input wire logic                     reset_n,
  input wire logic                     dev_wake_o,
  input wire logic                     dev_wake_oe,
  input wire logic                     wake
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire is_single = mode == sfb_pkg::SFB_MODE_SINGLE;

  // Three idle cycles guarantee the bridge has left its data phase.
  sequence s_idle3;
    !is_single && wr_n && $past(wr_n) && $past(wr_n, 2) && reset_n
      && $past(reset_n, 3);
  endsequence
  sequence s_cmd;
    !is_single && wr_n ##1 !wr_n;
  endsequence

  property p_oe_drive;
    is_single |-> dev_data_oe == {W{~oe_n}};
  endproperty
  a_oe_drive: assert property (p_oe_drive)
    else $error("data drive differs from output enable");
  property p_core_rst;
    !reset_n |=> rx_avail_flag_n;
  endproperty
  a_core_rst: assert property (p_core_rst)
    else $error("receive flag low after chip reset");
  property p_host_rst;
    $past(rst) |-> !reset_n;
  endproperty
  a_host_rst: assert property (p_host_rst)
    else $error("chip reset released too early");
  property p_bus_clk;
    $past(reset_n) && !$past(rst) |-> bus_clk != $past(bus_clk);
  endproperty
  a_bus_clk: assert property (p_bus_clk)
    else $error("bus clock did not toggle");
  property p_rd_gate;
    is_single && !rd_n |-> !rx_avail_flag_n;
  endproperty
  a_rd_gate: assert property (p_rd_gate)
    else $error("read strobe while no data waits");
  property p_wake_od;
    dev_wake_oe |-> !dev_wake_o && !wake;
  endproperty
  a_wake_od: assert property (p_wake_od)
    else $error("wake pin not low while the bridge drives it");
  property p_idle;
    s_idle3 |-> be == 4'hf && data[31:16] == 16'hffff && data[7:0] == 8'hff
      && data[15:13] == 3'h7 && data[11:9] == 3'h7 && !tx_space_flag_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle status pattern wrong");
  property p_data_ack;
    !is_single && !rx_avail_flag_n |-> !$past(wr_n);
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("data acknowledge without a command");
  property p_cmd;
    s_cmd |-> (be == 4'h0 || be == 4'h1) && data[7:0] == sfb_pkg::CHAN_ONE;
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command phase code or channel wrong");
endmodule

// [sfb_pkg.sv]
// Shared constants and types for both ends of the parallel FIFO bus.
// Assumes both ends and the interface are compiled after this package.
package sfb_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int          DATA_W       = 32;
  localparam int          BE_W         = 4;
  localparam int          FIFO_DEPTH   = 8;
  localparam int          STAT_LO      = 8;
  localparam int          STAT_OUT_BIT = 12;
  localparam int          STAT_IN_BIT  = 8;
  localparam logic [7:0]  STAT_FIELD   = 8'hff;
  localparam logic [7:0]  CHAN_ONE     = 8'h01;

  // ----------------------------------------------------------------------
  // Multi-channel command codes on the byte enables
  // ----------------------------------------------------------------------
  localparam logic [3:0]  BE_CMD_READ  = 4'h0;
  localparam logic [3:0]  BE_CMD_WRITE = 4'h1;
  localparam logic [3:0]  BE_IDLE      = 4'hf;

  // ----------------------------------------------------------------------
  // Bus clock rates and supply limits
  // ----------------------------------------------------------------------
  localparam int          BUS_KHZ_SLOW = 66670;
  localparam int          BUS_KHZ_FAST = 100000;
  localparam int          IO_MV_LOW    = 1800;
  localparam int          IO_MV_FAST   = 2500;

  typedef enum logic {SFB_MODE_SINGLE, SFB_MODE_MULTI} sfb_mode_t;

endpackage

// [test_sync_fifo_bus_slave_signals.sv]
// Self-checking bench joining the bridge end to the master end.
// Assumes both ends share clk; inputs change on the falling edge.
`timescale 1ns/10ps
module test_sync_fifo_bus_slave_signals;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  localparam int      LIMIT = 20000;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  sfb_pkg::sfb_mode_t mode = sfb_pkg::SFB_MODE_SINGLE;
  logic               usb_suspend = 1'b0;
  logic               chip_reset = 1'b0;
  logic               wake_req = 1'b0;
  logic [31:0]        usb_rx_data = 32'h0;
  logic               usb_rx_valid = 1'b0;
  logic               usb_tx_ready = 1'b0;
  logic [31:0]        send_data = 32'h0;
  logic               send_valid = 1'b0;
  logic               recv_ready = 1'b0;
  logic               usb_rx_ready, usb_tx_valid, send_ready, recv_valid;
  logic               remote_wakeup, core_reset, suspended;
  logic [31:0]        usb_tx_data, recv_data;
  int                 fail_count = 0;
  int                 comparisons = 0;
  int                 cycles = 0;

  always #12.5 clk = ~clk;
  sfb_if sfb_if_i ();
  sfb_dev sfb_dev_i (.clk, .rst, .mode, .usb_suspend, .remote_wakeup,
    .core_reset, .usb_rx_data, .usb_rx_valid, .usb_rx_ready, .usb_tx_data,
    .usb_tx_valid, .usb_tx_ready, .bus(sfb_if_i));
  sfb_host sfb_host_i (.clk, .rst, .mode, .chip_reset, .wake_req, .suspended,
    .send_data, .send_valid, .send_ready, .recv_data, .recv_valid,
    .recv_ready, .bus(sfb_if_i));
  sfb_monitor sfb_monitor_i (.clk, .rst, .mode, .bus_clk(sfb_if_i.bus_clk),
    .data(sfb_if_i.data), .dev_data_oe(sfb_if_i.dev_data_oe),
    .be(sfb_if_i.be), .tx_space_flag_n(sfb_if_i.tx_space_flag_n),
    .rx_avail_flag_n(sfb_if_i.rx_avail_flag_n), .wr_n(sfb_if_i.wr_n),
    .rd_n(sfb_if_i.rd_n), .oe_n(sfb_if_i.oe_n),
    .reset_n(sfb_if_i.reset_n), .dev_wake_o(sfb_if_i.dev_wake_o),
    .dev_wake_oe(sfb_if_i.dev_wake_oe), .wake(sfb_if_i.wake));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask

  // Mode only changes under reset, so neither end sees a half transfer.
  task automatic rst_to(input sfb_pkg::sfb_mode_t m);
    @(negedge clk);
    rst = 1'b1;
    mode = m;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic push_rx(input logic [31:0] d);
    usb_rx_valid = 1'b1;
    usb_rx_data = d;
    while (usb_rx_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    usb_rx_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic send(input logic [31:0] d);
    send_valid = 1'b1;
    send_data = d;
    while (send_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    send_valid = 1'b0;
    @(negedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_single_write;
    int n;
    rst_to(sfb_pkg::SFB_MODE_SINGLE);
    usb_tx_ready = 1'b0;
    check(sfb_if_i.tx_space_flag_n, 1'b0, "space flag");
    for (int i = 0; i < 9; i++)
      send(32'ha5000000 + i);
    repeat (4) @(negedge clk);
    check(sfb_if_i.tx_space_flag_n, 1'b1, "full flag");
    usb_tx_ready = 1'b1;
    n = 0;
    while (n < 9)
    begin
      if (usb_tx_valid === 1'b1)
      begin
        check(usb_tx_data, 32'ha5000000 + n, "written word");
        n++;
      end
      @(negedge clk);
    end
    $display("test single write done");
  endtask

  task automatic t_single_read;
    int n;
    rst_to(sfb_pkg::SFB_MODE_SINGLE);
    recv_ready = 1'b0;
    check(sfb_if_i.rx_avail_flag_n, 1'b1, "empty flag");
    // The output stage holds one word ahead of the eight-word buffer.
    for (int i = 0; i < 9; i++)
      push_rx(32'h5a000000 + i);
    repeat (3) @(negedge clk);
    check(usb_rx_ready, 1'b0, "rx buffer full");
    check(sfb_if_i.rx_avail_flag_n, 1'b0, "data flag");
    recv_ready = 1'b1;
    n = 0;
    while (n < 9)
    begin
      @(negedge clk);
      if (recv_valid === 1'b1)
      begin
        check(recv_data, 32'h5a000000 + n, "read word");
        n++;
      end
    end
    repeat (3) @(negedge clk);
    check(sfb_if_i.rx_avail_flag_n, 1'b1, "drained flag");
    $display("test single read done");
  endtask

  task automatic t_multi;
    rst_to(sfb_pkg::SFB_MODE_MULTI);
    check(sfb_if_i.data[15:8], 8'hfe, "idle status");
    usb_tx_ready = 1'b1;
    send(32'hc3c30001);
    while (usb_tx_valid !== 1'b1) @(negedge clk);
    check(usb_tx_data, 32'hc3c30001, "multi write");
    recv_ready = 1'b1;
    push_rx(32'h3c3c0002);
    while (recv_valid !== 1'b1) @(negedge clk);
    check(recv_data, 32'h3c3c0002, "multi read");
    $display("test multi channel done");
  endtask

  task automatic t_wake_reset;
    logic hit;
    rst_to(sfb_pkg::SFB_MODE_SINGLE);
    check(sfb_if_i.wake, 1'b0, "wake active");
    usb_suspend = 1'b1;
    repeat (3) @(negedge clk);
    check(sfb_if_i.wake, 1'b1, "wake suspend");
    check(suspended, 1'b1, "suspended");
    wake_req = 1'b1;
    hit = 1'b0;
    repeat (10)
    begin
      @(negedge clk);
      if (remote_wakeup === 1'b1)
        hit = 1'b1;
    end
    check(hit, 1'b1, "remote wakeup");
    wake_req = 1'b0;
    usb_suspend = 1'b0;
    chip_reset = 1'b1;
    repeat (3) @(negedge clk);
    check(core_reset, 1'b1, "core reset held");
    chip_reset = 1'b0;
    repeat (4) @(negedge clk);
    check(core_reset, 1'b0, "core reset free");
    $display("test wake and reset done");
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      end_sim();
    end
  end

  initial
  begin
    t_single_write();
    t_single_read();
    t_multi();
    t_wake_reset();
    end_sim();
  end
endmodule
